// ### hw/rtu_link_if.sv
// Query/response link between the bus master and one slave
`timescale 1ns/10ps
interface rtu_link_if (input logic mclk);
   logic qry_end;
   logic [7:0] qry_addr;
   logic [7:0] qry_func;
   logic [7:0] qry_cnt;
   logic [7:0] qry_wcnt;
   logic [7:0] qry_total;
   logic [7:0] qry_wtotal;
   logic qry_err;
   logic qry_cfg;
   logic rsp_valid;
   logic [7:0] rsp_exc;
   logic rsp_ack;
   logic cfg_busy;
   modport dev (input qry_end, qry_addr, qry_func, qry_cnt, qry_wcnt, qry_total,
      qry_wtotal, qry_err, qry_cfg, rsp_ack, output rsp_valid, rsp_exc, cfg_busy);
   modport mst (output qry_end, qry_addr, qry_func, qry_cnt, qry_wcnt, qry_total,
      qry_wtotal, qry_err, qry_cfg, rsp_ack, input rsp_valid, rsp_exc, cfg_busy);
endinterface : rtu_link_if

// ### hw/rtu_map.svh
// Constants for the serial-bus slave supervision block and its master
`ifndef RTU_MAP_SVH
`define RTU_MAP_SVH
`define RTU_CLK_MHZ 50
`define RTU_APPLY_MAX_US 2000
`define RTU_CFG_MAX_US 1000000
`define RTU_APPLY_MAX_CYC (`RTU_APPLY_MAX_US * `RTU_CLK_MHZ)
`define RTU_CFG_MAX_CYC (`RTU_CFG_MAX_US * `RTU_CLK_MHZ)
`define RTU_FC_RD 8'h03
`define RTU_FC_WR1 8'h06
`define RTU_FC_DIAG 8'h08
`define RTU_FC_WRN 8'h10
`define RTU_FC_RW 8'h17
`define RTU_EXC_NONE 8'h00
`define RTU_EXC_FUNC 8'h01
`define RTU_EXC_RANGE 8'h03
`define RTU_EXC_BUSY 8'h04
`define RTU_ERR_TX 8'h84
`define RTU_ERR_UNDEF 8'h88
`define RTU_ERR_UI 8'h89
`define RTU_ERR_NVM 8'h8A
`define RTU_ERR_RANGE 8'h8C
`define RTU_ERR_DIS 8'h8D
`define RTU_ALM_BUS 8'h81
`define RTU_ALM_TX 8'h84
`define RTU_ALM_TMO 8'h85
`define RTU_AXIS_MAX 8'h18
`define RTU_RD_TOTAL 8'h7D
`define RTU_WR_TOTAL 8'h7B
`define RTU_RW_WTOTAL 8'h79
`define RTU_BCAST 8'h00
`define RTU_HOST_CMD 4'h0
`define RTU_HOST_CNT 4'h1
`define RTU_HOST_GO 4'h2
`define RTU_HOST_STAT 4'h3
`endif

// ### hw/rtu_master.sv
// Master end: issues queries from software registers and collects replies
`timescale 1ns/10ps
module rtu_master import rtu_pkg::*; #(
   parameter int CFG_MAX_CYC = `RTU_CFG_MAX_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Software register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Link to the slaves
   rtu_link_if.mst link
);
   localparam logic [31:0] CFG_MAX = 32'(CFG_MAX_CYC);

   logic [31:0] cmd_q, cnt_reg_q, rdata_q, hold_q;
   logic busy_q, refused_q, done_q, end_q;
   logic [7:0] left_q, exc_q;

   ////////////////////////////////////////////////////////////////////////////
   // Command fields: addr, func, config, corrupt, shared, axes
   wire [7:0] c_addr = cmd_q[7:0];
   wire [7:0] c_func = cmd_q[15:8];
   wire c_cfg = cmd_q[16];
   wire c_err = cmd_q[17];
   wire c_shr = cmd_q[18];
   wire [7:0] c_axes = cmd_q[31:24];
   wire c_wr = c_func == `RTU_FC_WR1 || c_func == `RTU_FC_WRN || c_func == `RTU_FC_RW;
   wire go = wr && addr == `RTU_HOST_GO && !busy_q;
   wire lim_bad = c_shr && !rtu_shared_ok(c_func, cnt_reg_q[7:0], cnt_reg_q[15:8],
      cnt_reg_q[23:16], cnt_reg_q[31:24], c_axes);                      // [R19] [R20] [R22]
   // No register write while a configuration may still be running
   wire cfg_hold = hold_q != 32'h0000_0000 || link.cfg_busy;
   wire refuse = lim_bad || (c_wr && cfg_hold);                         // [R3]
   wire send = go && !refuse;
   wire [7:0] expect_n = c_addr == `RTU_BCAST || c_err ? 8'h00 : (c_shr ? c_axes : 8'h01);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cmd_q <= 32'h0000_0000;
         cnt_reg_q <= 32'h0000_0000;
      end else if (wr && !busy_q) begin
         if (addr == `RTU_HOST_CMD) cmd_q <= wdata;
         if (addr == `RTU_HOST_CNT) cnt_reg_q <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         refused_q <= 1'b0;
         done_q <= 1'b0;
         end_q <= 1'b0;
         left_q <= 8'h00;
         exc_q <= 8'h00;
         hold_q <= 32'h0000_0000;
      end else begin
         end_q <= send;
         if (go) begin
            refused_q <= refuse;
            busy_q <= send && expect_n != 8'h00;
            done_q <= refuse || (send && expect_n == 8'h00);
            left_q <= expect_n;
         end else if (busy_q && link.rsp_valid) begin
            exc_q <= link.rsp_exc;
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
         if (send && c_cfg) hold_q <= CFG_MAX;
         else if (hold_q != 32'h0000_0000) hold_q <= hold_q - 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `RTU_HOST_CMD: rdata_q <= cmd_q;
            `RTU_HOST_CNT: rdata_q <= cnt_reg_q;
            `RTU_HOST_STAT: rdata_q <= {8'h00, left_q, exc_q, 4'h0, cfg_hold, refused_q,
               done_q, busy_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link drive; fields stay registered from the command registers
   assign rdata = rdata_q;
   assign link.qry_end = end_q;
   assign link.qry_addr = c_addr;
   assign link.qry_func = c_func;
   assign link.qry_cnt = cnt_reg_q[7:0];
   assign link.qry_wcnt = cnt_reg_q[15:8];
   assign link.qry_total = cnt_reg_q[23:16];
   assign link.qry_wtotal = cnt_reg_q[31:24];
   assign link.qry_err = c_err;
   assign link.qry_cfg = c_cfg;
   assign link.rsp_ack = busy_q && link.rsp_valid;
endmodule : rtu_master

// ### hw/rtu_pkg.sv
// Types and shared register-count checks for the supervision block
`include "rtu_map.svh"
package rtu_pkg;
   typedef logic [7:0] rtu_byte_t;
   typedef enum logic [1:0] {RTU_IDLE, RTU_WAIT, RTU_TURN, RTU_SEND} rtu_state_e;

   function automatic logic rtu_in(input rtu_byte_t v, input rtu_byte_t hi);
      return (v != 8'h00) && (v <= hi);
   endfunction : rtu_in

   // Shared mode budget; read total loses one check slot per axis
   function automatic logic rtu_shared_ok(input rtu_byte_t fc, input rtu_byte_t cnt,
         input rtu_byte_t wcnt, input rtu_byte_t tot, input rtu_byte_t wtot,
         input rtu_byte_t axes);
      rtu_byte_t rlim;
      rlim = `RTU_RD_TOTAL - axes;
      case (fc)
         `RTU_FC_RD: return rtu_in(cnt, `RTU_AXIS_MAX) && rtu_in(tot, rlim);
         `RTU_FC_WRN: return rtu_in(cnt, `RTU_AXIS_MAX) && rtu_in(tot, `RTU_WR_TOTAL);
         `RTU_FC_RW: return rtu_in(cnt, `RTU_AXIS_MAX) && rtu_in(wcnt, `RTU_AXIS_MAX)
            && rtu_in(tot, rlim) && rtu_in(wtot, `RTU_RW_WTOTAL);
         default: return 1'b1;
      endcase
   endfunction : rtu_shared_ok
endpackage : rtu_pkg

// ### hw/rtu_slave_dev.sv
// Slave end: timing, error codes, alarms, information and shared-address replies
// Functional notes
// R1 - Reply after silent gap plus longer wait
// R2 - Apply change within gap, processing, 2 ms
// R3 - Configuration ends within 1 s; no writes
// R4 - Link indicator red only for code 84h
// R5 - Keep readable volatile error history
// R6 - Map exceptions to error codes 84h..8Dh
// R7 - Bus alarm: outputs flip, motor stops, red
// R8 - Link_indicator power falling edge raises alarm 81h
// R9 - Consecutive transmission errors raise alarm 84h
// R10 - Communication timeout raises alarm 85h
// R11 - Information keeps motor running, blinks blue
// R12 - Error run over threshold; good frame resets
// R13 - Processing time over limit raises information
// R14 - Communication interval over limit raises information
// R15 - Group member accepts shared group address
// R16 - Group members reply in ascending rank
// R17 - Group size and distinct ranks are master's
// R18 - Member still serves unicast and broadcast
// R19 - Shared read/write register count limits
// R20 - Shared read-write register count limits
// R21 - Shared mode refuses single write, diagnosis
// R22 - Shared read total loses one per axis
// R23 - Wait for all lower ranks to finish
// R24 - Ignore shared address when unset or mismatched
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rtu_slave_dev import rtu_pkg::*; #(
   parameter int HIST_DEPTH = 8,
   parameter int APPLY_MAX_CYC = `RTU_APPLY_MAX_CYC,
   parameter int CFG_MAX_CYC = `RTU_CFG_MAX_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Link to the master
   rtu_link_if.dev link,
   // Addressing
   input wire logic [7:0] own_addr,
   input wire logic [7:0] group_shared_address,
   input wire logic [7:0] group_size,
   input wire logic [7:0] member_response_rank,
   input wire logic peer_done,
   // Timing settings in clock cycles
   input wire logic [19:0] silent_interval,
   input wire logic [19:0] query_processing_time,
   input wire logic [19:0] transmit_wait_time,
   input wire logic [19:0] apply_lag,
   // Supervision settings
   input wire logic [7:0] err_detect_count,
   input wire logic [7:0] consecutive_error_info_threshold,
   input wire logic [31:0] processing_time_info_limit,
   input wire logic [31:0] interval_info_limit,
   input wire logic [31:0] link_indicator_timeout,
   input wire logic [2:0] power_loss_action,
   input wire logic link_indicator_power,
   // Application status
   input wire logic ui_busy,
   input wire logic nvm_busy,
   input wire logic exec_disable,
   input wire logic cfg_done,
   input wire logic alarm_clear,
   input wire logic info_clear,
   // History read port
   input wire logic [$clog2(HIST_DEPTH)-1:0] hist_idx,
   output logic [7:0] hist_data,
   output logic [7:0] last_error,
   // Indicators and actions
   output logic alarm_output_active_high,
   output logic alarm_output_active_low,
   output logic motor_stop,
   output logic [7:0] alarm_code,
   output logic [2:0] info_flags,
   output logic [1:0] power_system_indicator,
   output logic link_indicator,
   output logic apply_pulse
);
   localparam int HW = $clog2(HIST_DEPTH);
   localparam logic [31:0] APPLY_MAX = 32'(APPLY_MAX_CYC);
   localparam logic [31:0] CFG_MAX = 32'(CFG_MAX_CYC);

   rtu_state_e st_q;
   logic [31:0] cnt_q, ivl_q, cfg_cnt_q;
   logic [7:0] exc_q, err_run_q, peer_q, alm_code_q, last_q, hist_rd_q;
   logic shr_q, bc_q, act_q, cfg_q, cfg_busy_q, alm_q, red_q, pwr_s1_q, pwr_s2_q, pwr_d_q;
   logic apply_q;
   logic [2:0] info_q;
   logic [7:0] hist_q [HIST_DEPTH];
   logic [HW-1:0] wptr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Address and function decode
   wire own_hit = link.qry_addr == own_addr;
   wire bc_hit = link.qry_addr == `RTU_BCAST;
   wire shr_hit = (group_size != 8'h00) && (link.qry_addr == group_shared_address)
      && !bc_hit && !own_hit;                                          // [R15] [R24]
   wire take = link.qry_end && !link.qry_err && (own_hit || bc_hit || shr_hit)
      && st_q == RTU_IDLE;                                             // [R18]
   wire tx_err = link.qry_end && link.qry_err;
   wire [7:0] fc = link.qry_func;
   wire fc_rd = fc == `RTU_FC_RD;
   wire fc_w1 = fc == `RTU_FC_WR1;
   wire fc_wn = fc == `RTU_FC_WRN;
   wire fc_rw = fc == `RTU_FC_RW;
   wire fc_dg = fc == `RTU_FC_DIAG;
   wire is_wr = fc_w1 || fc_wn || fc_rw;
   wire undef = !(fc_rd || fc_w1 || fc_wn || fc_rw || fc_dg)
      || (shr_hit && (fc_w1 || fc_dg));                                 // [R21]
   wire uni_ok = fc_rd ? rtu_in(link.qry_cnt, `RTU_RD_TOTAL)
      : fc_wn ? rtu_in(link.qry_cnt, `RTU_WR_TOTAL)
      : fc_rw ? rtu_in(link.qry_cnt, `RTU_RD_TOTAL)
         && rtu_in(link.qry_wcnt, `RTU_RW_WTOTAL) : 1'b1;
   wire shr_ok = rtu_shared_ok(fc, link.qry_cnt, link.qry_wcnt, link.qry_total,
      link.qry_wtotal, group_size);                                     // [R19] [R20] [R22]
   wire bad_rng = shr_hit ? !shr_ok : !uni_ok;
   // Priority: undefined, range, then the busy/disable refusals
   wire [7:0] exc_d = undef ? `RTU_EXC_FUNC : bad_rng ? `RTU_EXC_RANGE
      : ((ui_busy || nvm_busy || exec_disable) && is_wr) ? `RTU_EXC_BUSY : `RTU_EXC_NONE;
   wire [7:0] code_d = link.qry_err ? `RTU_ERR_TX : undef ? `RTU_ERR_UNDEF
      : bad_rng ? `RTU_ERR_RANGE : ui_busy ? `RTU_ERR_UI
      : nvm_busy ? `RTU_ERR_NVM : `RTU_ERR_DIS;                         // [R6]
   wire err_ev = tx_err || (take && exc_d != `RTU_EXC_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Timing points, counted from the end of the query
   wire [31:0] wait_max = 32'(silent_interval) + 32'(query_processing_time > transmit_wait_time
      ? query_processing_time : transmit_wait_time);
   wire [31:0] lag = 32'(apply_lag) > APPLY_MAX ? APPLY_MAX : 32'(apply_lag);
   wire [31:0] apply_at = 32'(silent_interval) + 32'(query_processing_time) + lag;
   wire my_turn = !shr_q || ({24'h0000_00, peer_q} + 32'h0000_0001
      >= 32'(member_response_rank));                                    // [R16] [R23]
   wire send_go = st_q == RTU_WAIT && cnt_q >= wait_max && !bc_q;
   wire done_bc = st_q == RTU_WAIT && bc_q && cnt_q >= apply_at;
   wire fire = act_q && cnt_q == apply_at;          // [R2]
   wire rsp_start = st_q == RTU_TURN && my_turn;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_q <= RTU_IDLE;
      end else begin
         case (st_q)
            RTU_IDLE: if (take) st_q <= RTU_WAIT;
            RTU_WAIT: if (send_go) st_q <= RTU_TURN;                    // [R1]
               else if (done_bc) st_q <= RTU_IDLE;
            RTU_TURN: if (rsp_start) st_q <= RTU_SEND;
            RTU_SEND: if (link.rsp_ack) st_q <= RTU_IDLE;
            default: st_q <= RTU_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt_q <= 32'h0000_0000;
         exc_q <= 8'h00;
         shr_q <= 1'b0;
         bc_q <= 1'b0;
         act_q <= 1'b0;
         cfg_q <= 1'b0;
         peer_q <= 8'h00;
         apply_q <= 1'b0;
      end else begin
         apply_q <= fire;
         cnt_q <= take ? 32'h0000_0000 : (cnt_q == 32'hFFFF_FFFF ? cnt_q : cnt_q + 32'h0000_0001);
         peer_q <= take ? 8'h00 : (peer_done ? peer_q + 8'h01 : peer_q);
         if (take) begin
            exc_q <= exc_d;
            shr_q <= shr_hit;
            bc_q <= bc_hit;
            act_q <= exc_d == `RTU_EXC_NONE && (is_wr || link.qry_cfg);
            cfg_q <= link.qry_cfg;
         end
         if (fire) begin
            act_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration hold: ends on completion or at the 1 s ceiling
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg_busy_q <= 1'b0;
         cfg_cnt_q <= 32'h0000_0000;
      end else if (fire && cfg_q) begin
         cfg_busy_q <= 1'b1;
         cfg_cnt_q <= 32'h0000_0000;
      end else if (cfg_busy_q) begin
         cfg_cnt_q <= cfg_cnt_q + 32'h0000_0001;
         if (cfg_done || cfg_cnt_q + 32'h0000_0001 >= CFG_MAX) cfg_busy_q <= 1'b0; // [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error history, volatile: only reset clears it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wptr_q <= '0;
         last_q <= 8'h00;
         hist_rd_q <= 8'h00;
         for (int i = 0; i < HIST_DEPTH; i++) hist_q[i] <= 8'h00;
      end else begin
         hist_rd_q <= hist_q[hist_idx];
         if (err_ev) begin
            hist_q[wptr_q] <= code_d;                                   // [R5]
            wptr_q <= wptr_q + 1'b1;
            last_q <= code_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supervision: error run, interval, power edge, alarms and information
   wire good = take && exc_d == `RTU_EXC_NONE;
   wire [7:0] run_nx = err_run_q == 8'hFF ? err_run_q : err_run_q + 8'h01;
   wire pwr_fall = pwr_d_q && !pwr_s2_q;
   wire act_alm = power_loss_action >= 3'd1 && power_loss_action <= 3'd4;
   wire a81 = pwr_fall && act_alm;                                      // [R8]
   wire a84 = tx_err && err_detect_count != 8'h00 && run_nx >= err_detect_count; // [R9]
   wire a85 = link_indicator_timeout != 32'h0000_0000 && ivl_q >= link_indicator_timeout;   // [R10]
   wire i_err = tx_err && run_nx > consecutive_error_info_threshold;    // [R12]
   wire i_prc = rsp_start && cnt_q > processing_time_info_limit;        // [R13]
   wire i_ivl = take && ivl_q > interval_info_limit;                    // [R14]

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         err_run_q <= 8'h00;
         ivl_q <= 32'h0000_0000;
         pwr_s1_q <= 1'b1;
         pwr_s2_q <= 1'b1;
         pwr_d_q <= 1'b1;
         red_q <= 1'b0;
      end else begin
         pwr_s1_q <= link_indicator_power;
         pwr_s2_q <= pwr_s1_q;
         pwr_d_q <= pwr_s2_q;
         if (tx_err) err_run_q <= run_nx;
         else if (good) err_run_q <= 8'h00;                             // [R12]
         if (tx_err) red_q <= 1'b1;                                     // [R4]
         else if (good) red_q <= 1'b0;
         ivl_q <= take ? 32'h0000_0000
            : (ivl_q == 32'hFFFF_FFFF ? ivl_q : ivl_q + 32'h0000_0001);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         alm_q <= 1'b0;
         alm_code_q <= 8'h00;
         info_q <= 3'b000;
      end else begin
         info_q <= (info_clear ? 3'b000 : info_q) | {i_ivl, i_prc, i_err};
         if (!alm_q && (a81 || a84 || a85)) begin
            alm_q <= 1'b1;
            alm_code_q <= a81 ? `RTU_ALM_BUS : a84 ? `RTU_ALM_TX : `RTU_ALM_TMO;
         end else if (alarm_clear && !(a81 || a84 || a85)) begin
            alm_q <= 1'b0;
            alm_code_q <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign link.rsp_valid = st_q == RTU_SEND;
   assign link.rsp_exc = exc_q;
   assign link.cfg_busy = cfg_busy_q;
   assign hist_data = hist_rd_q;
   assign last_error = last_q;
   assign alarm_output_active_high = alm_q;                             // [R7]
   assign alarm_output_active_low = !alm_q;
   assign motor_stop = alm_q;                                           // [R11]
   assign alarm_code = alm_code_q;
   assign info_flags = info_q;
   // Alarm blink red outranks information blink blue
   assign power_system_indicator = alm_q ? 2'b01 : (info_q != 3'b000 ? 2'b10 : 2'b00); // [R7] [R11]
   assign link_indicator = red_q;
   assign apply_pulse = apply_q;
endmodule : rtu_slave_dev

// ### tb/rtu_link_assertions.sv
// Link checker: timing, refusal and configuration-hold relations on the query/reply link
`timescale 1ns/10ps
module rtu_link_chk #(
   parameter int CFG_MAX_CYC = 200,
   parameter logic [7:0] GROUP_ADDR = 8'h0F
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Query side
   input wire logic qry_end,
   input wire logic [7:0] qry_addr,
   input wire logic [7:0] qry_func,
   input wire logic [7:0] qry_cnt,
   input wire logic qry_err,
   // Reply side
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_exc,
   input wire logic rsp_ack,
   input wire logic cfg_busy
);
   int cfg_q;
   wire shared_q = qry_end && (qry_addr == GROUP_ADDR);
   wire wr_q = qry_end && (qry_func inside {8'h06, 8'h10, 8'h17});
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Length of the current configuration hold
   always_ff @(posedge mclk) begin
      cfg_q <= (!rstn || !cfg_busy) ? 0 : cfg_q + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_reply_late: assert property (qry_end |=> !rsp_valid [*8])
      else $error("reply started inside the silent wait");
   a_no_reply: assert property (qry_end && qry_err |=> !rsp_valid [*8] ##1 !rsp_valid [*8])
      else $error("reply to a corrupt frame");
   a_shared_refuse: assert property (shared_q && (qry_func inside {8'h06, 8'h08})
      |-> ##[9:60] (rsp_valid && rsp_exc == 8'h01))
      else $error("shared single write or diagnosis not refused");
   a_shared_count: assert property (shared_q && qry_func == 8'h03
      |-> qry_cnt inside {[8'h01:8'h18]})
      else $error("shared read count outside the per-axis range");
   a_cfg_no_write: assert property (cfg_busy |-> !wr_q)
      else $error("write issued during configuration");
   a_cfg_bound: assert property (cfg_q <= CFG_MAX_CYC)
      else $error("configuration lasted too long");
   a_ack_release: assert property (rsp_ack |=> !rsp_valid)
      else $error("reply held after ack");
   a_single_reply: assert property ($fell(rsp_valid) |-> !rsp_valid [*8])
      else $error("second reply overlaps the first");
   c_exc: cover property (rsp_valid && rsp_ack && rsp_exc != 8'h00);
   c_cfg: cover property (cfg_busy);
   c_err: cover property (qry_end && qry_err);
endmodule : rtu_link_chk

// ### tb/tb_top.sv
// Bench: master and slave joined on one link, driven through the register port
`timescale 1ns/10ps
module tb_top;
   logic mclk = 0, rstn = 0, wr = 0, rd = 0, peer_done = 0, link_indicator_power = 1, ui_busy = 0;
   logic nvm_busy = 0, exec_disable = 0, cfg_done = 0, alarm_clear = 0, info_clear = 0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, st;
   logic [7:0] own_addr = 8'h05, group_shared_address = 8'h0F, group_size = 8'h02;
   logic [7:0] member_response_rank = 8'h01, err_detect_count = 8'h03;
   logic [7:0] consecutive_error_info_threshold = 8'h01, hist_data, last_error, alarm_code;
   logic [19:0] silent_interval = 20'h4, query_processing_time = 20'h3;
   logic [19:0] transmit_wait_time = 20'h6, apply_lag = 20'h5;
   logic [31:0] processing_time_info_limit = 32'h00FF_FFFF, link_indicator_timeout = 32'h0;
   logic [31:0] interval_info_limit = 32'h00FF_FFFF;
   logic [2:0] power_loss_action = 3'h1, hist_idx = 3'h0, info_flags;
   logic [1:0] power_system_indicator;
   logic alarm_output_active_high, alarm_output_active_low, motor_stop, link_indicator;
   logic apply_pulse;
   int fails = 0, checks_done = 0, k, tmo = 0, cyc = 0, lag = 0;
   logic [31:0] ec [5] = '{32'h0000_0505, 32'h0000_0305, 32'h0000_1005, 32'h0000_1005,
      32'h0000_1005};
   logic [7:0] ex [5] = '{8'h01, 8'h03, 8'h04, 8'h04, 8'h04};
   logic [7:0] cd [5] = '{8'h88, 8'h8C, 8'h89, 8'h8A, 8'h8D};

   rtu_link_if i_rtu_link_if (.mclk(mclk));
   rtu_master #(.CFG_MAX_CYC(200)) i_rtu_master (.*, .link(i_rtu_link_if.mst));
   rtu_slave_dev #(.APPLY_MAX_CYC(20), .CFG_MAX_CYC(200)) i_rtu_slave_dev (.*,
      .link(i_rtu_link_if.dev));
   rtu_link_chk #(.CFG_MAX_CYC(200)) i_rtu_link_chk (.mclk(mclk), .rstn(rstn),
      .qry_end(i_rtu_link_if.qry_end), .qry_addr(i_rtu_link_if.qry_addr),
      .qry_func(i_rtu_link_if.qry_func), .qry_cnt(i_rtu_link_if.qry_cnt),
      .qry_err(i_rtu_link_if.qry_err), .rsp_valid(i_rtu_link_if.rsp_valid),
      .rsp_exc(i_rtu_link_if.rsp_exc), .rsp_ack(i_rtu_link_if.rsp_ack),
      .cfg_busy(i_rtu_link_if.cfg_busy));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #10 mclk = ~mclk;
   end
   // Cycles since the last query end, and a ceiling on the whole run
   always @(posedge mclk) begin
      tmo <= tmo + 1;
      cyc <= i_rtu_link_if.qry_end ? 0 : cyc + 1;
      if (apply_pulse === 1'b1) lag <= cyc;
      if (tmo == 30000) begin
         fails++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   // An idle cycle follows each strobe so no strobe is set twice in one step
   task wreg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge mclk);
      wr <= 0;
      @(posedge mclk);
   endtask : wreg
   task rreg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1;
      @(posedge mclk);
      rd <= 0;
      #1 d = rdata;
      @(posedge mclk);
   endtask : rreg
   task go(input logic [31:0] c, input logic [31:0] n);
      wreg(4'h0, c);
      wreg(4'h1, n);
      wreg(4'h2, 32'h0);
   endtask : go
   task wt();
      for (int i = 0; i < 200; i++) begin
         rreg(4'h3, st);
         if (st[0] === 1'b0) break;
      end
      chk("busy", st[0], 1'b0);
   endtask : wt
   task q(input logic [31:0] c, input logic [31:0] n);
      go(c, n);
      wt();
   endtask : q
   task pulse_wait();
      repeat (3) @(posedge mclk);
   endtask : pulse_wait
   task test_done();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1;
      @(posedge mclk);
      q(32'h0000_0305, 32'h0002_0002);
      chk("plain exc", st[15:8], 8'h00);
      // Every exception path, with the busy source picked per entry
      for (k = 0; k < 5; k++) begin
         {ui_busy, nvm_busy, exec_disable} <= (k < 2) ? 3'h0 : 3'(3'h4 >> (k - 2));
         q(ec[k], (k == 1) ? 32'h0 : 32'h0002_0002);
         chk("exc", st[15:8], ex[k]);
         chk("code", last_error, cd[k]);
         chk("link", link_indicator, 1'b0);
      end
      {ui_busy, nvm_busy, exec_disable} <= 3'h0;
      chk("hist", hist_data, 8'h88);
      processing_time_info_limit <= 32'h0000_0005;
      interval_info_limit <= 32'h0000_0005;
      q(32'h0000_0305, 32'h0002_0002);
      chk("info", info_flags, 3'b110);
      chk("psi", power_system_indicator, 2'b10);
      chk("run", motor_stop, 1'b0);
      processing_time_info_limit <= 32'h00FF_FFFF;
      interval_info_limit <= 32'h00FF_FFFF;
      info_clear <= 1;
      pulse_wait();
      info_clear <= 0;
      // Shared address: refusals, budgets, and rank order
      q(32'h0104_060F, 32'h0002_0002);
      chk("sh06", st[15:8], 8'h01);
      q(32'h0104_080F, 32'h0002_0002);
      chk("sh08", st[15:8], 8'h01);
      q(32'h0204_030F, 32'h0032_0019);
      chk("rd25", st[2], 1'b1);
      q(32'h0204_030F, 32'h007C_0002);
      chk("rd124", st[2], 1'b1);
      q(32'h0204_100F, 32'h007C_0002);
      chk("wr124", st[2], 1'b1);
      q(32'h0204_170F, 32'h7A04_0202);
      chk("rw122", st[2], 1'b1);
      q(32'h0104_030F, 32'h007B_0018);
      chk("rd123", st[2:1], 2'b01);
      member_response_rank <= 8'h02;
      go(32'h0104_030F, 32'h0004_0002);
      repeat (30) @(posedge mclk);
      rreg(4'h3, st);
      chk("rank", st[0], 1'b1);
      peer_done <= 1;
      @(posedge mclk);
      peer_done <= 0;
      wt();
      chk("rank2", st[15:8], 8'h00);
      // Configuration: apply timing, hold, refused write
      q(32'h0001_1005, 32'h0002_0002);
      chk("lag", (lag >= 9) && (lag <= 16), 1'b1);
      chk("cfg", i_rtu_link_if.cfg_busy, 1'b1);
      q(32'h0000_1005, 32'h0002_0002);
      chk("cfgwr", st[2], 1'b1);
      cfg_done <= 1;
      pulse_wait();
      cfg_done <= 0;
      chk("cfgend", i_rtu_link_if.cfg_busy, 1'b0);
      repeat (210) @(posedge mclk);
      q(32'h0000_0300, 32'h0);
      chk("bc", last_error, 8'h8C);
      // Transmission error run, broken once by a good frame
      repeat (2) q(32'h0002_0305, 32'h0002_0002);
      chk("errinfo", info_flags[0], 1'b1);
      q(32'h0000_0305, 32'h0002_0002);
      repeat (2) q(32'h0002_0305, 32'h0002_0002);
      chk("reset", motor_stop, 1'b0);
      q(32'h0002_0305, 32'h0002_0002);
      chk("alm84", alarm_code, 8'h84);
      chk("outs", {alarm_output_active_high, alarm_output_active_low, motor_stop},
         3'b101);
      chk("psi", power_system_indicator, 2'b01);
      chk("red", {link_indicator, last_error}, {1'b1, 8'h84});
      q(32'h0000_0305, 32'h0002_0002);
      alarm_clear <= 1;
      pulse_wait();
      alarm_clear <= 0;
      link_indicator_timeout <= 32'h0000_0032;
      repeat (60) @(posedge mclk);
      chk("alm85", alarm_code, 8'h85);
      link_indicator_timeout <= 32'h0;
      alarm_clear <= 1;
      pulse_wait();
      alarm_clear <= 0;
      link_indicator_power <= 0;
      repeat (6) @(posedge mclk);
      chk("alm81", alarm_code, 8'h81);
      test_done();
   end
endmodule : tb_top
